// ---- core/mac_filter_defs.svh ----
// offsets, field positions, reset values and counts of the mac control block
// assumes inclusion by bare name from the design file
`ifndef MAC_FILTER_DEFS_SVH
`define MAC_FILTER_DEFS_SVH
// ==========================================================
// csr indices
`define IDX_CTRL      8'h01
`define IDX_ADDR_HI   8'h02
`define IDX_ADDR_LO   8'h03
`define IDX_HASH_HI   8'h04
`define IDX_HASH_LO   8'h05
`define IDX_WAKE      8'h0c
// ==========================================================
// reset values of the control and address words, write masks of the control and wake words
`define CTRL_RESET    32'h0004_0000
`define CTRL_WMASK    32'h80bf_bdff
`define ADDR_HI_RESET 32'h0000_ffff
`define ADDR_LO_RESET 32'hffff_ffff
`define WAKE_WMASK    32'h0000_0002
// ==========================================================
// control and wake bit positions
`define BIT_HASH_ONLY 15
`define BIT_HASH_PERF 13
`define BIT_LATE_RTY  12
`define BIT_BC_REJ    11
`define BIT_SINGLE    10
`define BIT_PAD_STRIP 8
`define BIT_WAKE_EN   1
// ==========================================================
// counts
`define MAX_ATTEMPTS  5'd16
`define PAD_MIN_LEN   16'd46
`define HDR_LEN       16'd14
`define LEN_HI_POS    16'd12
`define LEN_LO_POS    16'd13
`endif

// ---- core/mac_filter_pkg.sv ----
// types of the mac filter and retry control block
// assumes the defs header sits on the include path
`default_nettype none
package mac_filter_pkg;
  // ========================================================
  // carriers
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  index;
    logic [31:0] wdata;
  } csr_req_t;
  typedef struct packed {
    logic        valid;
    logic [47:0] da;
    logic [5:0]  hash_idx;
    logic        wake_frame;
  } da_req_t;
  typedef struct packed {
    logic       valid;
    logic       collision;
    logic       late;
  } tx_end_t;
  typedef struct packed {
    logic       done;
    logic       late_collision;
    logic       retry_error;
  } tx_status_t;
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } rx_byte_t;
  // ========================================================
  // whole state of the block
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] addr_hi;
    logic [31:0] addr_lo;
    logic [31:0] hash_hi;
    logic [31:0] hash_lo;
    logic [31:0] wake;
    logic        ack;
    logic [31:0] rdata;
    logic        accept_valid;
    logic        accept;
    logic        wake_event;
    logic [4:0]  attempts;
    logic        tx_retry;
    tx_status_t  tx_status;
    logic [15:0] rx_count;
    logic [15:0] rx_len;
    logic        rx_drop;
    rx_byte_t    rx_out;
  } mac_state_t;
endpackage
`default_nettype wire

// ---- core/mac_filter_retry_control.sv ----
// mac control word with address filter, tx retry policy and rx pad strip
// assumes all inputs come from mac logic on the same clock, indirect csr port
//
// Behaviour
// - hash/perfect clear: accept only destinations equal to station address, plus broadcasts unless rejected
// - hash/perfect set: multicast destinations checked in the hash table
// - hash/perfect set: individual hashed if hash-only set, else perfect
// - late retry set: retransmit after late collision; clear: abandon frame
// - late collision always recorded in transmit status
// - broadcast reject set drops broadcasts; clear forwards them all
// - wake detect enabled: broadcast wake frame wakes despite reject
// - single attempt: one try, collision drops frame with retry error
// - otherwise up to 16 attempts before retry error
// - pad strip and length below 46: drop pad and fcs
// - pad strip and length 46 or more: frame unmodified with fcs
// - pad strip clear: every frame passed unmodified
// - hash-only is bit 15, hashing physical and multicast addresses when hash/perfect set
`timescale 1ns/1ps
`default_nettype none
`include "mac_filter_defs.svh"
module mac_filter_retry_control
  import mac_filter_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire mac_filter_pkg::csr_req_t csr_req,
  output var  logic                    csr_ack,
  output var  logic [31:0]             csr_rdata,
  input  wire mac_filter_pkg::da_req_t  da_req,
  output var  logic                    rx_accept_valid,
  output var  logic                    rx_accept,
  output var  logic                    wake_event,
  input  wire mac_filter_pkg::tx_end_t  tx_end,
  output var  logic                    tx_retry,
  output var  mac_filter_pkg::tx_status_t tx_status,
  input  wire mac_filter_pkg::rx_byte_t rx_in,
  output var  mac_filter_pkg::rx_byte_t rx_out
);
  import mac_filter_pkg::*;

  mac_state_t st;
  mac_state_t next_st;
  logic       hpf;
  logic       ho;
  logic [47:0] station;

  // ==========================================================
  // helpers
  function automatic logic hash_hit(input logic [31:0] hi, input logic [31:0] lo,
                                    input logic [5:0] idx);
    hash_hit = idx[5] ? hi[idx[4:0]] : lo[idx[4:0]];
  endfunction

  assign hpf     = st.ctrl[`BIT_HASH_PERF];
  assign ho      = st.ctrl[`BIT_HASH_ONLY];
  assign station = {st.addr_hi[15:0], st.addr_lo};

  // ==========================================================
  // next state
  always_comb
  begin
    logic        broadcast_reject;
    logic        hit;
    logic        match;
    logic        give_up;
    logic [4:0]  tries;
    logic [15:0] len_now;
    logic [15:0] keep_end;
    logic        strip;
    logic        cut;
    broadcast_reject    = 1'b0;
    hit      = 1'b0;
    match    = 1'b0;
    give_up  = 1'b0;
    tries    = 5'd0;
    len_now  = 16'd0;
    keep_end = 16'd0;
    strip    = 1'b0;
    cut      = 1'b0;
    next_st  = st;
    next_st.ack          = 1'b0;
    next_st.accept_valid = 1'b0;
    next_st.wake_event   = 1'b0;
    next_st.tx_retry     = 1'b0;
    next_st.tx_status    = '0;
    next_st.rx_out       = '0;

    // csr port: one-cycle answer, unmapped indices read zero
    if (csr_req.valid)
    begin
      next_st.ack   = 1'b1;
      next_st.rdata = 32'h0000_0000;
      unique case (csr_req.index)
        `IDX_CTRL:
        begin
          if (csr_req.write)
            next_st.ctrl = csr_req.wdata & `CTRL_WMASK;
          next_st.rdata = st.ctrl;
        end
        `IDX_ADDR_HI:
        begin
          if (csr_req.write)
            next_st.addr_hi = {16'h0000, csr_req.wdata[15:0]};
          next_st.rdata = st.addr_hi;
        end
        `IDX_ADDR_LO:
        begin
          if (csr_req.write)
            next_st.addr_lo = csr_req.wdata;
          next_st.rdata = st.addr_lo;
        end
        `IDX_HASH_HI:
        begin
          if (csr_req.write)
            next_st.hash_hi = csr_req.wdata;
          next_st.rdata = st.hash_hi;
        end
        `IDX_HASH_LO:
        begin
          if (csr_req.write)
            next_st.hash_lo = csr_req.wdata;
          next_st.rdata = st.hash_lo;
        end
        `IDX_WAKE:
        begin
          if (csr_req.write)
            next_st.wake = csr_req.wdata & `WAKE_WMASK;
          next_st.rdata = st.wake;
        end
        default: next_st.rdata = 32'h0000_0000;
      endcase
      if (csr_req.write)
        next_st.rdata = 32'h0000_0000; // writes answer zero
    end

    // destination address check, one verdict per request
    if (da_req.valid)
    begin
      broadcast_reject = &da_req.da;
      hit   = hash_hit(st.hash_hi, st.hash_lo, da_req.hash_idx);
      match = (da_req.da == station);
      next_st.accept_valid = 1'b1;
      if (broadcast_reject)
        next_st.accept = !st.ctrl[`BIT_BC_REJ];
      else if (!hpf)
        next_st.accept = match;
      else if (da_req.da[0])
        next_st.accept = hit;
      else
        next_st.accept = ho ? hit : match;
      // wake path ignores the reject bit on purpose
      next_st.wake_event = st.wake[`BIT_WAKE_EN] && broadcast_reject && da_req.wake_frame;
    end

    // transmit attempt outcome and retry policy
    if (tx_end.valid)
    begin
      tries = st.attempts + 5'd1;
      next_st.tx_status.late_collision = tx_end.late;
      if (!tx_end.collision && !tx_end.late)
      begin
        next_st.tx_status.done = 1'b1;
        next_st.attempts       = 5'd0;
      end
      else
      begin
        give_up = st.ctrl[`BIT_SINGLE] || tries >= `MAX_ATTEMPTS;
        if (tx_end.late && !st.ctrl[`BIT_LATE_RTY] && !give_up)
        begin
          next_st.tx_status.done = 1'b1;
          next_st.attempts       = 5'd0;
        end
        else if (give_up)
        begin
          next_st.tx_status.done        = 1'b1;
          next_st.tx_status.retry_error = 1'b1;
          next_st.attempts              = 5'd0;
        end
        else
        begin
          next_st.tx_retry = 1'b1;
          next_st.attempts = tries;
        end
      end
    end

    // receive pad strip; length is known once byte 13 arrives
    if (rx_in.valid)
    begin
      len_now  = (st.rx_count == `LEN_LO_POS) ? {st.rx_len[7:0], rx_in.data} : st.rx_len;
      keep_end = `HDR_LEN + len_now;
      strip    = st.ctrl[`BIT_PAD_STRIP] && st.rx_count >= `LEN_LO_POS
                 && len_now < `PAD_MIN_LEN;
      cut      = strip && st.rx_count == keep_end - 16'd1;
      if (st.rx_count == `LEN_HI_POS)
        next_st.rx_len = {8'h00, rx_in.data};
      else if (st.rx_count == `LEN_LO_POS)
        next_st.rx_len = len_now;
      if (!st.rx_drop)
      begin
        next_st.rx_out.valid = 1'b1;
        next_st.rx_out.data  = rx_in.data;
        next_st.rx_out.last  = rx_in.last || cut;
      end
      next_st.rx_drop  = st.rx_drop || (cut && !rx_in.last);
      next_st.rx_count = st.rx_count + 16'd1;
      if (rx_in.last)
      begin
        next_st.rx_count = 16'd0;
        next_st.rx_drop  = 1'b0;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st         <= '0;
      st.ctrl    <= `CTRL_RESET;
      st.addr_hi <= `ADDR_HI_RESET;
      st.addr_lo <= `ADDR_LO_RESET;
    end
    else
      st <= next_st;
  end

  assign csr_ack         = st.ack;
  assign csr_rdata       = st.rdata;
  assign rx_accept_valid = st.accept_valid;
  assign rx_accept       = st.accept;
  assign wake_event      = st.wake_event;
  assign tx_retry        = st.tx_retry;
  assign tx_status       = st.tx_status;
  assign rx_out          = st.rx_out;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_collided;
    tx_end.valid && (tx_end.collision || tx_end.late);
  endsequence

  a_perfect_filter: assert property (da_req.valid && !hpf && !(&da_req.da) |=>
    rx_accept == ($past(da_req.da) == $past(station))) else $error("perfect filter wrong");
  a_hash_multicast: assert property (da_req.valid && hpf && da_req.da[0] && !(&da_req.da)
    |=> rx_accept == $past(hash_hit(st.hash_hi, st.hash_lo, da_req.hash_idx)))
    else $error("multicast hash wrong");
  a_individual_mode: assert property (da_req.valid && hpf && !da_req.da[0] && !ho |=>
    rx_accept == ($past(da_req.da) == $past(station))) else $error("individual perfect wrong");
  a_late_abandon: assert property (s_collided ##0 tx_end.late && !st.ctrl[`BIT_LATE_RTY]
    |=> !tx_retry && tx_status.done) else $error("late collision retried");
  a_late_status: assert property (tx_end.valid |=>
    tx_status.late_collision == $past(tx_end.late)) else $error("late status lost");
  a_broadcast_reject_reject: assert property (da_req.valid && (&da_req.da) && st.ctrl[`BIT_BC_REJ]
    |=> rx_accept_valid && !rx_accept) else $error("broadcast accepted");
  a_wake_broadcast_reject: assert property (da_req.valid && (&da_req.da) && da_req.wake_frame
    && st.wake[`BIT_WAKE_EN] |=> wake_event) else $error("wake missed");
  a_single_try: assert property (s_collided ##0 st.ctrl[`BIT_SINGLE]
    |=> tx_status.retry_error && !tx_retry && st.attempts == 5'd0)
    else $error("single attempt retried");
  a_sixteen_max: assert property (st.attempts <= 5'd15) else $error("attempts overrun");
  a_reserved_zero: assert property (st.ctrl[9] == 1'b0) else $error("reserved bit set");
  a_no_strip_off: assert property (rx_in.valid && !st.ctrl[`BIT_PAD_STRIP] && !st.rx_drop
    |=> rx_out.valid && rx_out.data == $past(rx_in.data)) else $error("byte lost");
endmodule
`default_nettype wire

// ---- test/phy_model.sv ----
// receive side of the phy: streams one frame of bytes into the block
// assumes the bench calls send_frame from its main sequence
`timescale 1ns/1ps
`default_nettype none
module phy_model
  import mac_filter_pkg::*;
(
  input  wire logic                     clock,
  output var  mac_filter_pkg::rx_byte_t rx_in
);
  // ==========================================================
  // frame source
  initial rx_in = '0;
  // byte k carries k, except the length field in bytes 12 and 13
  task automatic send_frame(input int n, input logic [15:0] len);
    for (int k = 0; k < n; k++)
    begin
      @(posedge clock);
      rx_in.valid <= 1'b1;
      rx_in.last  <= (k == n - 1);
      rx_in.data  <= (k == 12) ? len[15:8] : (k == 13) ? len[7:0] : k[7:0];
    end
    // idle line flips its data so a stale byte never passes for good
    @(posedge clock);
    rx_in <= '{valid: 1'b0, last: 1'b0, data: ~rx_in.data};
  endtask
endmodule
`default_nettype wire

// ---- test/mac_filter_retry_control_tb.sv ----
// self-checking bench of the mac filter and retry control block
// assumes the design package and the phy model are compiled first
`timescale 1ns/1ps
`default_nettype none
module mac_filter_retry_control_tb;
  import mac_filter_pkg::*;
  logic        clock, sys_rst, csr_ack, rx_accept_valid, rx_accept, wake_event, tx_retry;
  logic [31:0] csr_rdata;
  logic [15:0] cur_len;
  csr_req_t    csr_req;
  da_req_t     da_req;
  tx_end_t     tx_end;
  tx_status_t  tx_status;
  rx_byte_t    rx_in, rx_out;
  int          n_mismatch, checked, cyc, rx_cnt, rx_last_at;
  localparam logic [47:0] sta = 48'h5544_3322_1102;
  localparam logic [47:0] oth = 48'h5544_3322_1202;
  localparam logic [47:0] mc  = 48'h0a00_0000_0001;
  localparam logic [47:0] bc  = 48'hffff_ffff_ffff;
  mac_filter_retry_control i_dut (.clock(clock), .sys_rst(sys_rst), .csr_req(csr_req),
    .csr_ack(csr_ack), .csr_rdata(csr_rdata), .da_req(da_req),
    .rx_accept_valid(rx_accept_valid), .rx_accept(rx_accept), .wake_event(wake_event),
    .tx_end(tx_end), .tx_retry(tx_retry), .tx_status(tx_status), .rx_in(rx_in),
    .rx_out(rx_out));
  phy_model i_phy (.clock(clock), .rx_in(rx_in));
  // ==========================================================
  // clock, watchdog and rx monitor
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      final_report;
    end
    if (rx_out.valid)
    begin
      chk(33'(rx_out.data), 33'((rx_cnt == 12) ? cur_len[15:8] :
          (rx_cnt == 13) ? cur_len[7:0] : rx_cnt[7:0]));
      if (rx_out.last)
        rx_last_at = rx_cnt;
      rx_cnt++;
    end
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one csr cycle; writes answer zero
  task automatic csr(input logic w, input logic [7:0] i, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge clock);
    csr_req <= '{valid: 1'b1, write: w, index: i, wdata: d};
    @(posedge clock);
    csr_req.valid <= 1'b0;
    #1 chk({csr_ack, csr_rdata}, {1'b1, w ? 32'h0 : e});
  endtask
  // e is {accept, wake}
  task automatic flt(input logic [47:0] da, input logic [5:0] hi, input logic wk,
                     input logic [1:0] e);
    @(posedge clock);
    da_req <= '{valid: 1'b1, da: da, hash_idx: hi, wake_frame: wk};
    @(posedge clock);
    da_req.valid <= 1'b0;
    #1 chk(33'({rx_accept_valid, rx_accept, wake_event}), 33'({1'b1, e}));
  endtask
  // e is {retry, done, late, retry error}
  task automatic txe(input logic c, input logic l, input logic [3:0] e);
    @(posedge clock);
    tx_end <= '{valid: 1'b1, collision: c, late: l};
    @(posedge clock);
    tx_end.valid <= 1'b0;
    #1 chk(33'({tx_retry, tx_status}), 33'(e));
  endtask
  task automatic rxf(input logic [15:0] len, input int n_exp, input int last_exp);
    cur_len = len;
    rx_cnt = 0;
    rx_last_at = 0;
    i_phy.send_frame(64, len);
    repeat (3) @(posedge clock);
    chk(33'(rx_cnt), 33'(n_exp));
    chk(33'(rx_last_at), 33'(last_exp));
  endtask
  // ==========================================================
  // scenarios
  task automatic regs_test;
    csr(1'b0, 8'h01, 32'h0, 32'h0004_0000);
    csr(1'b1, 8'h01, 32'h0000_0200, 32'h0);
    csr(1'b0, 8'h01, 32'h0, 32'h0);
    csr(1'b0, 8'h7f, 32'h0, 32'h0);
    csr(1'b1, 8'h02, 32'h0000_5544, 32'h0);
    csr(1'b1, 8'h03, 32'h3322_1102, 32'h0);
    csr(1'b1, 8'h05, 32'h0000_0008, 32'h0);
    csr(1'b0, 8'h02, 32'h0, 32'h0000_5544);
    csr(1'b0, 8'h03, 32'h0, 32'h3322_1102);
    csr(1'b0, 8'h05, 32'h0, 32'h0000_0008);
  endtask
  task automatic filter_test;
    flt(sta, 6'd3, 1'b0, 2'b10);
    flt(oth, 6'd3, 1'b0, 2'b00);
    flt(mc, 6'd3, 1'b0, 2'b00);
    csr(1'b1, 8'h01, 32'h0000_2000, 32'h0);
    flt(mc, 6'd3, 1'b0, 2'b10);
    flt(mc, 6'd4, 1'b0, 2'b00);
    flt(oth, 6'd3, 1'b0, 2'b00);
    csr(1'b1, 8'h01, 32'h0000_a000, 32'h0);
    flt(oth, 6'd3, 1'b0, 2'b10);
    flt(sta, 6'd4, 1'b0, 2'b00);
    csr(1'b1, 8'h01, 32'h0000_8000, 32'h0);
    flt(oth, 6'd3, 1'b0, 2'b00);
  endtask
  task automatic broadcast_reject_test;
    csr(1'b1, 8'h01, 32'h0000_0800, 32'h0);
    flt(bc, 6'd0, 1'b0, 2'b00);
    csr(1'b1, 8'h01, 32'h0, 32'h0);
    flt(bc, 6'd0, 1'b0, 2'b10);
    csr(1'b1, 8'h0c, 32'h0000_0002, 32'h0);
    csr(1'b0, 8'h0c, 32'h0, 32'h0000_0002);
    csr(1'b1, 8'h01, 32'h0000_0800, 32'h0);
    flt(bc, 6'd0, 1'b1, 2'b01);
  endtask
  task automatic tx_test;
    txe(1'b1, 1'b1, 4'b0110);
    csr(1'b1, 8'h01, 32'h0000_1000, 32'h0);
    txe(1'b1, 1'b1, 4'b1010);
    txe(1'b0, 1'b0, 4'b0100);
    csr(1'b1, 8'h01, 32'h0000_0400, 32'h0);
    txe(1'b1, 1'b0, 4'b0101);
    csr(1'b1, 8'h01, 32'h0, 32'h0);
    repeat (15) txe(1'b1, 1'b0, 4'b1000);
    txe(1'b1, 1'b0, 4'b0101);
  endtask
  task automatic rx_test;
    csr(1'b1, 8'h01, 32'h0000_0100, 32'h0);
    rxf(16'd4, 18, 17);
    rxf(16'd45, 59, 58);
    rxf(16'd46, 64, 63);
    csr(1'b1, 8'h01, 32'h0, 32'h0);
    rxf(16'd4, 64, 63);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    csr_req = '0;
    da_req = '0;
    tx_end = '0;
    sys_rst = 1'b1;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    regs_test;
    filter_test;
    broadcast_reject_test;
    tx_test;
    rx_test;
    final_report;
  end
endmodule
`default_nettype wire
